// ===== tb_tbip_port.sv
// Self-checking bench of the two-bit input port against a register model.
// Assumes word addressing and a one-cycle waitrequest answer per access.
`include "tbip_map.svh"

module tb_tbip_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clock = 1'b0;
  logic                rstn = 1'b0;
  logic [15:0]         address = 16'h0;
  logic                read = 1'b0;
  logic                write = 1'b0;
  logic [31:0]         writedata = 32'h0;
  logic [3:0]          byteenable = 4'h0;
  logic [31:0]         readdata;
  logic                waitrequest;
  logic [1:0]          pin_lvl;
  logic                ext = 1'b0;
  logic                clk_src_en = 1'b0;
  logic [1:0]          drive_en = 2'h3;
  logic [1:0]          drive_val = 2'h0;
  tbip_pkg::tbip_pad_s pad;
  int                  err_count = 0;
  int                  check_count = 0;
  logic [1:0]          lo_m = 2'h0;
  logic [1:0]          hi_m = 2'h0;
  logic [31:0]         r;
  logic [1:0]          lo;
  logic [1:0]          hi;

  // 125 MHz clock
  always #4 clock = ~clock;

  tbip_port tbip_port_inst (.address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in(pin_lvl), .ext_clock_mode_bit(ext),
    .pad_ctrl(pad), .clock(clock), .rstn(rstn));
  tbip_pins_model tbip_pins_model_inst (.clock(clock), .drive_en(drive_en),
    .drive_val(drive_val), .clk_src_en(clk_src_en), .pad_ctrl(pad), .pin_lvl(pin_lvl));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One Avalon access, held until waitrequest is seen low; one idle edge after
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    if (n >= 20) begin
      err_count++;
      tally_and_finish();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus

  // Write and update the model; refused writes leave it alone
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] rd;
    bus(1'b1, a, d, be, rd);
    if (a == `TBIP_OFS_PULL_LO && be[0]) lo_m = d[1:0];
    if (a == `TBIP_OFS_PULL_LO && be[1]) hi_m = d[9:8];
    if (a == `TBIP_OFS_PULL_HI && be == `TBIP_BE_BYTE0) hi_m = d[1:0];
  endtask : wr

  // Read and compare the bits selected by mask with the model
  task automatic rd_chk(input logic [15:0] a, input logic [1:0] pins, input logic [31:0] m);
    logic [31:0] rd;
    logic [31:0] e;
    e = 32'h0;
    if (a == `TBIP_OFS_LEVEL) e = {30'h0, pins[1], pins[0] & ~ext};
    if (a == `TBIP_OFS_PULL_LO) e = {22'h0, hi_m, 6'h0, lo_m};
    if (a == `TBIP_OFS_PULL_HI) e = {30'h0, hi_m};
    bus(1'b0, a, 32'h0, (a == `TBIP_OFS_PULL_LO) ? 4'h3 : `TBIP_BE_BYTE0, rd);
    chk("readdata", e & m, rd & m);
  endtask : rd_chk

  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    void'($urandom(43472));
    @(posedge clock);
    chk("pad_ctrl", 32'h0, {28'h0, pad});
    rd_chk(`TBIP_OFS_PULL_LO, 2'h0, 32'hFFFF_FFFF);
    rd_chk(`TBIP_OFS_PULL_HI, 2'h0, 32'hFFFF_FFFF);
    for (int p = 0; p < 4; p++) begin
      drive_val <= p[1:0];
      repeat (4) @(posedge clock);
      rd_chk(`TBIP_OFS_LEVEL, p[1:0], 32'hFFFF_FFFF);
    end
    // External clock on pin 0, both pins still driven high by the bench
    ext <= 1'b1;
    clk_src_en <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(`TBIP_OFS_LEVEL, 2'h3, 32'hFFFF_FFFF);
    ext <= 1'b0;
    clk_src_en <= 1'b0;
    drive_en <= 2'h0;
    // Every select code on both pins, random reserved bits
    for (int c = 0; c < 16; c++) begin
      r = $urandom();
      lo = {c[2], c[0]};
      hi = {c[3], c[1]};
      wr(`TBIP_OFS_PULL_LO, (r & 32'hFFFF_FCFC) | {22'h0, hi, 6'h0, lo}, 4'h3);
      repeat (3) @(posedge clock);
      chk("pad_ctrl", {28'h0, hi & ~lo, lo & ~hi}, {28'h0, pad});
      rd_chk(`TBIP_OFS_PULL_LO, 2'h0, 32'hFFFF_FFFF);
      rd_chk(`TBIP_OFS_LEVEL, hi & ~lo, {30'h0, lo ^ hi});
    end
    r = $urandom();
    wr(`TBIP_OFS_PULL_HI, r, `TBIP_BE_BYTE0);
    wr(`TBIP_OFS_PULL_HI, ~r, 4'h3);
    wr(`TBIP_OFS_PULL_LO, ~r, `TBIP_BE_BYTE0);
    wr(`TBIP_OFS_LEVEL, 32'hFFFF_FFFF, 4'hF);
    wr(16'hF209, 32'hFFFF_FFFF, 4'hF);
    rd_chk(`TBIP_OFS_PULL_HI, 2'h0, 32'hFFFF_FFFF);
    rd_chk(`TBIP_OFS_PULL_LO, 2'h0, 32'hFFFF_FFFF);
    rd_chk(16'hF209, 2'h0, 32'hFFFF_FFFF);
    // Load both registers, read the low one as a byte, then reset mid-run
    wr(`TBIP_OFS_PULL_LO, 32'h0000_0201, 4'h3);
    @(posedge clock);
    chk("pad_ctrl", {28'h0, hi_m & ~lo_m, lo_m & ~hi_m}, {28'h0, pad});
    bus(1'b0, `TBIP_OFS_PULL_LO, 32'h0, `TBIP_BE_BYTE0, r);
    chk("readdata", {30'h0, lo_m}, r);
    rstn <= 1'b0;
    lo_m = 2'h0;
    hi_m = 2'h0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk("pad_ctrl", 32'h0, {28'h0, pad});
    rd_chk(`TBIP_OFS_PULL_LO, 2'h0, 32'hFFFF_FFFF);
    tally_and_finish();
  end
endmodule : tb_tbip_port

// ===== tbip_map.svh
// Register map, field positions and reset values of the two-bit input port.
// Assumes a 32-bit Avalon-MM slave with word addressing; included by bare name.
`ifndef TBIP_MAP_SVH
`define TBIP_MAP_SVH

// Register indices; the slave's word address equals the index
`define TBIP_OFS_LEVEL    16'hF208
`define TBIP_OFS_PULL_LO  16'hF20A
`define TBIP_OFS_PULL_HI  16'hF20B

// Field layout
`define TBIP_PINS         2
`define TBIP_PIN_MSB      1
`define TBIP_PIN0         0
`define TBIP_WORD_HI_LSB  8

// Reset value of both pull-select registers
`define TBIP_PULL_RESET   2'h0

// Byte enable pattern of a plain byte access on lane 0
`define TBIP_BE_BYTE0     4'h1

`endif

// ===== tbip_pins_model.sv
// Model of the two external pins, their resistors and an external clock source.
// Assumes pad_ctrl from the port; a pin nobody drives or pulls keeps changing.
module tbip_pins_model (
  input  wire logic                 clock,
  input  wire logic [1:0]           drive_en,
  input  wire logic [1:0]           drive_val,
  input  wire logic                 clk_src_en,
  input  wire tbip_pkg::tbip_pad_s  pad_ctrl,
  output logic      [1:0]           pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_q = 1'b0;

  // Changing pattern, so a floating pin never looks stable to the port
  always @(posedge clock) begin
    flip_q <= ~flip_q;
  end

  // Pin level: clock source, then driver, then resistor, else floating
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (i == 0 && clk_src_en) pin_lvl[i] = flip_q;     // Clock onto pin 0
      else if (drive_en[i]) pin_lvl[i] = drive_val[i];
      else if (pad_ctrl.pull_up[i]) pin_lvl[i] = 1'b1;
      else if (pad_ctrl.pull_down[i]) pin_lvl[i] = 1'b0;
      else pin_lvl[i] = flip_q ^ i[0];
    end
  end
endmodule : tbip_pins_model

// ===== tbip_pkg.sv
// Types shared by the two-bit input port and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package tbip_pkg;

  // Bus handshake states
  typedef enum logic {
    TBIP_BUS_IDLE,
    TBIP_BUS_ACK
  } tbip_bus_e;

  // Input mode of one pin
  typedef enum logic [1:0] {
    TBIP_PULL_NONE,
    TBIP_PULL_DOWN,
    TBIP_PULL_UP
  } tbip_pull_e;

  // Resistor controls towards the pad cells, one bit per pin
  typedef struct packed {
    logic [1:0] pull_up;
    logic [1:0] pull_down;
  } tbip_pad_s;

endpackage : tbip_pkg

// ===== tbip_port.sv
// Two-bit input port: pin level register and per-pin pull selection.
// Assumes an Avalon-MM master with word addressing, pins asynchronous to clock,
// and the clock generator's external clock mode bit arriving synchronous.
//
// Register access over Avalon-MM was left to the implementer.
`include "tbip_map.svh"

module tbip_port #(
  parameter int ADDR_W = 16
) (
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic [1:0]        pin_in,
  input  wire logic              ext_clock_mode_bit,
  output tbip_pkg::tbip_pad_s    pad_ctrl,
  input  wire logic              clock,
  input  wire logic              rstn
);

  localparam logic [ADDR_W-1:0] OFS_LEVEL   = ADDR_W'(`TBIP_OFS_LEVEL);
  localparam logic [ADDR_W-1:0] OFS_PULL_LO = ADDR_W'(`TBIP_OFS_PULL_LO);
  localparam logic [ADDR_W-1:0] OFS_PULL_HI = ADDR_W'(`TBIP_OFS_PULL_HI);

  tbip_pkg::tbip_bus_e bus_state_q;
  tbip_pkg::tbip_bus_e bus_state_d;
  logic                waitrequest_q;
  logic                waitrequest_d;
  logic [31:0]         readdata_q;
  logic [31:0]         readdata_d;
  logic [1:0]          pull_lo_q;
  logic [1:0]          pull_lo_d;
  logic [1:0]          pull_hi_q;
  logic [1:0]          pull_hi_d;
  tbip_pkg::tbip_pad_s pad_q;
  tbip_pkg::tbip_pad_s pad_d;
  logic [1:0]          level_sync;
  logic [1:0]          level_view;

  // Decode one pin's select pair into its input mode
  function automatic tbip_pkg::tbip_pull_e pull_decode(
    input logic hi,
    input logic lo
  );
    tbip_pkg::tbip_pull_e mode;
    case ({hi, lo})
      2'h1:    mode = tbip_pkg::TBIP_PULL_DOWN;
      2'h2:    mode = tbip_pkg::TBIP_PULL_UP;
      default: mode = tbip_pkg::TBIP_PULL_NONE;
    endcase
    return mode;
  endfunction : pull_decode

  // Read value of an address; upper bits stay zero
  function automatic logic [31:0] read_mux(
    input logic [ADDR_W-1:0] addr,
    input logic [3:0]        be,
    input logic [1:0]        level,
    input logic [1:0]        lo,
    input logic [1:0]        hi
  );
    logic [31:0] data;
    data = '0;
    if (addr == OFS_LEVEL) begin
      data[`TBIP_PIN_MSB:0] = level;
    end else if (addr == OFS_PULL_LO) begin
      data[`TBIP_PIN_MSB:0] = lo;
      if (be[1]) begin
        data[`TBIP_WORD_HI_LSB+`TBIP_PIN_MSB:`TBIP_WORD_HI_LSB] = hi;
      end
    end else if (addr == OFS_PULL_HI) begin
      data[`TBIP_PIN_MSB:0] = hi;
    end
    return data;
  endfunction : read_mux

  // Pin levels are asynchronous, so they are resynchronised first
  tbip_sync #(
    .WIDTH (`TBIP_PINS)
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   (pin_in),
    .dout  (level_sync)
  );

  // Pin 0 hides its level while it serves as the clock input
  always_comb begin
    level_view = level_sync;
    level_view[`TBIP_PIN0] = level_sync[`TBIP_PIN0] & ~ext_clock_mode_bit;
  end

  // Bus handshake: one wait cycle, then one cycle with waitrequest low.
  // Writes land at the edge where the master sees waitrequest low.
  always_comb begin
    bus_state_d   = bus_state_q;
    waitrequest_d = 1'b1;
    readdata_d    = readdata_q;
    pull_lo_d     = pull_lo_q;
    pull_hi_d     = pull_hi_q;
    case (bus_state_q)
      tbip_pkg::TBIP_BUS_IDLE: begin
        if (read || write) begin
          bus_state_d   = tbip_pkg::TBIP_BUS_ACK;
          waitrequest_d = 1'b0;
          if (read) begin
            readdata_d = read_mux(address, byteenable, level_view, pull_lo_q, pull_hi_q);
          end else begin
            readdata_d = '0;
          end
        end
      end
      tbip_pkg::TBIP_BUS_ACK: begin
        bus_state_d = tbip_pkg::TBIP_BUS_IDLE;
        if (write) begin
          if (address == OFS_PULL_LO) begin
            if (byteenable[0]) begin
              pull_lo_d = writedata[`TBIP_PIN_MSB:0];
            end
            if (byteenable[1]) begin
              // Word access spans into the high register
              pull_hi_d = writedata[`TBIP_WORD_HI_LSB+`TBIP_PIN_MSB:`TBIP_WORD_HI_LSB];
            end
          end else if (address == OFS_PULL_HI && byteenable == `TBIP_BE_BYTE0) begin
            pull_hi_d = writedata[`TBIP_PIN_MSB:0];
          end
          // Level register and unmapped addresses ignore writes
        end
      end
      default: begin
        bus_state_d = tbip_pkg::TBIP_BUS_IDLE;
      end
    endcase
  end

  // Register the bus and control state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_state_q   <= tbip_pkg::TBIP_BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q    <= '0;
      pull_lo_q     <= `TBIP_PULL_RESET;
      pull_hi_q     <= `TBIP_PULL_RESET;
    end else begin
      bus_state_q   <= bus_state_d;
      waitrequest_q <= waitrequest_d;
      readdata_q    <= readdata_d;
      pull_lo_q     <= pull_lo_d;
      pull_hi_q     <= pull_hi_d;
    end
  end

  // Pad controls; a pin never gets both resistors, and it is never driven
  always_comb begin
    pad_d = '0;
    for (int i = 0; i < `TBIP_PINS; i++) begin
      pad_d.pull_down[i] = (pull_decode(pull_hi_q[i], pull_lo_q[i])
                            == tbip_pkg::TBIP_PULL_DOWN);
      pad_d.pull_up[i]   = (pull_decode(pull_hi_q[i], pull_lo_q[i])
                            == tbip_pkg::TBIP_PULL_UP);
    end
  end

  // Pad register; one cycle behind the select bits, harmless for resistors
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;
  assign pad_ctrl    = pad_q;

  // Waitrequest drops for exactly one cycle, one edge after a request
  bus_ack_one_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_IDLE && (read || write))
      |=> !waitrequest ##1 waitrequest
  ) else $error("waitrequest did not pulse low for one cycle");

  // Outside clock mode a level read carries the twice-registered pins
  level_read_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_IDLE && read && address == OFS_LEVEL
     && !ext_clock_mode_bit && $past(rstn, 3))
      |=> readdata == {30'h0, $past(pin_in, 3)}
  ) else $error("level read does not match synchronised pins");

  // Clock mode forces the pin 0 bit low
  ext_mask_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_IDLE && read && address == OFS_LEVEL
     && ext_clock_mode_bit)
      |=> readdata[0] == 1'b0
  ) else $error("pin 0 level visible in external clock mode");

  // Pin 0 pull-down follows select 01 and pin 1 pull-up follows 10, one edge later
  pull_decode_a: assert property (
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> (pad_ctrl.pull_down[0] == ($past(pull_hi_q[0]) == 1'b0 && $past(pull_lo_q[0])))
          && (pad_ctrl.pull_up[1] == ($past(pull_hi_q[1]) && $past(pull_lo_q[1]) == 1'b0))
  ) else $error("pad controls disagree with select bits");

  // No pin ever has both resistors
  no_both_pulls_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (pad_ctrl.pull_up & pad_ctrl.pull_down) == 2'h0
  ) else $error("pull-up and pull-down enabled together");

  // A 16-bit write to the low register also loads the high register
  word_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_ACK && write && address == OFS_PULL_LO
     && byteenable[1:0] == 2'h3)
      |=> pull_hi_q == $past(writedata[9:8]) && pull_lo_q == $past(writedata[1:0])
  ) else $error("word write did not span both control registers");

  // Wider access to the high register is refused
  hi_byte_only_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_ACK && write && address == OFS_PULL_HI
     && byteenable != `TBIP_BE_BYTE0)
      |=> $stable(pull_hi_q) && $stable(pull_lo_q)
  ) else $error("non-byte write changed the high register");

  // Reads of any address leave bits above the low field of each byte zero
  reserved_zero_a: assert property (
    @(posedge clock) disable iff (!rstn)
    !waitrequest |-> (readdata & 32'hFFFF_FCFC) == 32'h0
  ) else $error("reserved read bits not zero");

  // Both control registers are clear right after reset release
  reset_clear_a: assert property (
    @(posedge clock) disable iff (!rstn)
    !$past(rstn) |-> pull_lo_q == 2'h0 && pull_hi_q == 2'h0 && pad_ctrl == '0
  ) else $error("control registers not cleared by reset");

  // A byte write to the low register loads only the low select bits
  pull_low_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_ACK && write && address == OFS_PULL_LO
     && byteenable[1:0] == 2'h1)
      |=> pull_lo_q == $past(writedata[1:0]) && $stable(pull_hi_q)
  ) else $error("byte write to the low register went astray");

  // A byte write to the high register loads only the high select bits
  pull_high_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_ACK && write && address == OFS_PULL_HI
     && byteenable == `TBIP_BE_BYTE0)
      |=> pull_hi_q == $past(writedata[1:0]) && $stable(pull_lo_q)
  ) else $error("byte write to the high register went astray");

  // Writes to the level register or unmapped addresses change no select bit
  stray_write_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_ACK && write && address != OFS_PULL_LO
     && address != OFS_PULL_HI)
      |=> $stable(pull_lo_q) && $stable(pull_hi_q)
  ) else $error("write outside the control registers changed a select bit");

  // Every pin: code 10 turns on the pull-up, 01 the pull-down, others neither
  pad_decode_a: assert property (
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> pad_ctrl.pull_up == ($past(pull_hi_q) & ~$past(pull_lo_q))
          && pad_ctrl.pull_down == ($past(pull_lo_q) & ~$past(pull_hi_q))
  ) else $error("pad controls disagree with select codes");

  // A word read of the low register returns both select bytes
  word_read_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_IDLE && read && address == OFS_PULL_LO
     && byteenable[1:0] == 2'h3)
      |=> readdata == {22'h0, $past(pull_hi_q), 6'h0, $past(pull_lo_q)}
  ) else $error("word read of the select registers is wrong");

  // The high register reads its select bits in the low byte
  high_read_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_IDLE && read && address == OFS_PULL_HI)
      |=> readdata == {30'h0, $past(pull_hi_q)}
  ) else $error("high select register read is wrong");

  // Unmapped addresses read as zero
  unmapped_read_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_IDLE && read && address != OFS_LEVEL
     && address != OFS_PULL_LO && address != OFS_PULL_HI)
      |=> readdata == 32'h0
  ) else $error("unmapped address read not zero");

  // Clock mode hides only pin 0; pin 1 still reads its synchronised level
  pin1_clock_mode_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bus_state_q == tbip_pkg::TBIP_BUS_IDLE && read && address == OFS_LEVEL
     && ext_clock_mode_bit && $past(rstn, 3))
      |=> readdata[1] == $past(pin_in[1], 3)
  ) else $error("pin 1 level lost in external clock mode");

endmodule : tbip_port

// ===== tbip_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes one clock and an active-low asynchronous reset.
module tbip_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  // Both stages clear to low; the pins take over two edges later
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule : tbip_sync
